// ---- hdl/rae_regs.vh ----
// Register offsets, field positions, reset values and timing counts for reset and alarm logic
`ifndef RAE_REGS_VH
`define RAE_REGS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RAE_ADDR_CFG_A 8'h00
`define RAE_ADDR_STAT_A 8'h11
`define RAE_ADDR_CFG_D 8'h14
`define RAE_ADDR_MASK 8'h16
`define RAE_ADDR_ERR 8'h17
`define RAE_PRIMARY_LAST 8'h1E
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RAE_CFGA_RST_HI 7
`define RAE_CFGA_RST_LO 0
`define RAE_CFGD_CRC_EN 6
`define RAE_CFGD_PULLUP 2
`define RAE_STAT_NOT_READY 7
`define RAE_STAT_BITCNT 4
`define RAE_STAT_SPICRC 3
`define RAE_STAT_RO 2
`define RAE_STAT_PART 1
`define RAE_STAT_INVAL 0
`define RAE_ERR_REF 6
`define RAE_ERR_MEMCRC 4
`define RAE_ERR_DUAL 1
`define RAE_ERR_RST 0
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RAE_CFGA_RESET 8'h10
`define RAE_CFGD_RESET 8'h04
`define RAE_MASK_RESET 8'h00
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RAE_CLK_HZ 25000000
`define RAE_INIT_MS 100
`define RAE_INIT_CYC ((`RAE_CLK_HZ / 1000) * `RAE_INIT_MS)
`define RAE_REF_MS 5
`define RAE_REF_CYC (((`RAE_CLK_HZ / 1000) * `RAE_REF_MS) + 1)
`define RAE_CRC_NS 4100
`define RAE_CRC_CYC ((`RAE_CLK_HZ / 1000000) * `RAE_CRC_NS / 1000)
`endif

// ---- hdl/rae_timer.v ----
// Counter that pulses once every programmable number of enabled cycles
module rae_timer #(
  parameter WIDTH = 24
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_run,
  input wire [WIDTH-1:0] i_limit,
  output reg o_done
);
  reg [WIDTH-1:0] cnt_r;
  // Count while running, restart when halted
  always @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      cnt_r <= {WIDTH{1'b0}};
      o_done <= 1'b0;
    end else if (cnt_r == i_limit - 1'b1) begin
      cnt_r <= {WIDTH{1'b0}};
      o_done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_done <= 1'b0;
    end
  end
endmodule // rae_timer

// ---- hdl/rae_flags.v ----
// Bank of sticky flags, set by hardware events, cleared by writing one
module rae_flags #(
  parameter N = 8
) (
  input wire i_clk,
  input wire i_rst,
  input wire [N-1:0] i_set,
  input wire i_clr_we,
  input wire [N-1:0] i_clr,
  output reg [N-1:0] o_flags
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      // Set wins over a clear in the same cycle
      always @(posedge i_clk) begin
        if (i_rst) begin
          o_flags[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_flags[g] <= 1'b1;
        end else if (i_clr_we && i_clr[g]) begin
          o_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // rae_flags

// ---- hdl/rae_alarm.v ----
// Reset sequencing, error flags and alarm output of a dual converter
// How it works
// - Reset pin low clears registers, zeroes outputs
// - Initialization lasts up to 100 ms
// - After reset cores stay powered down
// - Both request bits start soft reset
// - Request bits self-clear when reset finishes
// - Error flags sticky, write one clears
// - Mask register holds one bit per source
// - Unmasked set flag asserts alarm, except the dual-mode flag, which never does
// - Completed reset sets reset-status flag
// - Reset-status drives alarm, cannot be masked
// - Stuck alarm after clearing means init failure
// - Alarm releases once init has ended and all unmasked sources and reset-status clear
// - Internal pull-up follows pull-up enable bit
// - Reference below 1 V over 5 ms flags
// - Dual-mode stream into primary region flags
// - Memory CRC recomputed every 4.1 us
// - Enabled CRC mismatch sets memory CRC flag
// - Not-ready status bit, not an error
// - Clock count not whole bytes flags
// - Bad or missing serial CRC flags
// - Readonly_write_flag flags
// - Partial multibyte access flags
// - Unimplemented address access flags
// - Primary region ends at 0x1E
`include "rae_regs.vh"
module rae_alarm #(
  parameter INIT_CYC = `RAE_INIT_CYC,
  parameter REF_CYC = `RAE_REF_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_por,
  input wire i_reg_we,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  input wire i_ref_low,
  input wire i_crc_mismatch,
  input wire i_txn_end,
  input wire [7:0] i_txn_clocks,
  input wire [1:0] i_txn_mode,
  input wire i_txn_ddr,
  input wire i_spi_crc_bad,
  input wire i_ro_write,
  input wire i_partial,
  input wire i_bad_addr,
  input wire i_stream_step,
  input wire [7:0] i_stream_prev,
  input wire [7:0] i_stream_next,
  output wire o_core_reset,
  output wire o_outputs_zero,
  output wire o_cores_powerdown,
  output wire o_spi_hiz,
  output reg o_crc_strobe,
  output reg o_txn_reject,
  output wire o_alarm_o,
  output wire o_alarm_oe,
  output wire o_alarm_pullup_en
);
  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  // Hold lasts one cycle, init a fixed count, then run
  localparam ST_HOLD = 2'd0;
  localparam ST_INIT = 2'd1;
  localparam ST_RUN = 2'd2;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg soft_r;
  reg [7:0] cfg_a_r;
  reg [7:0] cfg_d_r;
  reg [7:0] mask_r;
  reg cores_pd_r;
  wire init_done;
  // Any hard source restarts the whole sequence
  wire hard = i_rst || i_por || !i_reset_n;
  wire soft_req;
  // Hold and init both count as not ready
  wire in_init = (state_r != ST_RUN);
  // Host writes are dropped until init ends
  wire wr_cfg_a = i_reg_we && (i_reg_addr == `RAE_ADDR_CFG_A) && !in_init;
  assign soft_req = wr_cfg_a && i_reg_wdata[`RAE_CFGA_RST_HI] && i_reg_wdata[`RAE_CFGA_RST_LO];
  assign o_core_reset = hard || in_init;
  assign o_outputs_zero = hard || in_init || cores_pd_r;
  assign o_spi_hiz = hard;
  assign o_cores_powerdown = cores_pd_r;
  // Initialization interval
  // Counts only in init, so a new reset restarts it
  rae_timer #(.WIDTH(32)) u_init (
    .i_clk(i_clk),
    .i_rst(hard),
    .i_run(state_r == ST_INIT),
    .i_limit(INIT_CYC),
    .o_done(init_done)
  );
  // Next-state selection
  // A soft request in run sends the sequencer back to init
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: state_nxt = ST_INIT;
      ST_INIT: if (init_done) state_nxt = ST_RUN;
      ST_RUN: if (soft_req) state_nxt = ST_INIT;
      default: state_nxt = ST_HOLD;
    endcase
  end
  // State and soft-reset tracking
  always @(posedge i_clk) begin
    if (hard) begin
      state_r <= ST_HOLD;
      soft_r <= 1'b0;
      cores_pd_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      // Remember that this init came from a soft request
      if (soft_req) begin
        soft_r <= 1'b1;
        cores_pd_r <= 1'b1;
      end else if (init_done) begin
        soft_r <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Writes only land once the device is ready
  wire wr_ok = i_reg_we && !in_init;
  // Config A survives soft reset
  // Request bits read back set until init completes
  always @(posedge i_clk) begin
    if (hard) begin
      cfg_a_r <= `RAE_CFGA_RESET;
    end else if (wr_cfg_a) begin
      cfg_a_r <= i_reg_wdata;
    end else if (init_done && soft_r) begin
      cfg_a_r[`RAE_CFGA_RST_HI] <= 1'b0;
      cfg_a_r[`RAE_CFGA_RST_LO] <= 1'b0;
    end
  end
  // Config D and mask, reset by every reset
  // Mask bit 7 has no source and always reads zero
  always @(posedge i_clk) begin
    if (hard || soft_req) begin
      cfg_d_r <= `RAE_CFGD_RESET;
      mask_r <= `RAE_MASK_RESET;
    end else if (wr_ok && i_reg_addr == `RAE_ADDR_CFG_D) begin
      cfg_d_r <= i_reg_wdata;
    end else if (wr_ok && i_reg_addr == `RAE_ADDR_MASK) begin
      mask_r <= {1'b0, i_reg_wdata[6:0]};
    end
  end
  // Pull-up enable
  // Without it an external pull-up must hold the pin
  assign o_alarm_pullup_en = cfg_d_r[`RAE_CFGD_PULLUP];
  // ---------------------------------------------------------------
  // Error detectors
  // ---------------------------------------------------------------
  wire ref_done;
  wire crc_tick;
  // Reference low timer
  // Restarts from zero whenever the reference recovers
  rae_timer #(.WIDTH(24)) u_ref (
    .i_clk(i_clk),
    .i_rst(hard || soft_req),
    .i_run(i_ref_low),
    .i_limit(REF_CYC[23:0]),
    .o_done(ref_done)
  );
  // Period count cut to the timer width on purpose
  wire [31:0] crc_lim_full = `RAE_CRC_CYC;
  // Periodic CRC tick, only while checking is on
  rae_timer #(.WIDTH(8)) u_crc (
    .i_clk(i_clk),
    .i_rst(hard || soft_req),
    .i_run(cfg_d_r[`RAE_CFGD_CRC_EN] && !in_init),
    .i_limit(crc_lim_full[7:0]),
    .o_done(crc_tick)
  );
  // Mismatch is judged one cycle after the tick
  reg crc_pend_r;
  // Strobe and mismatch capture
  // Strobe tells the checker outside when to compare
  always @(posedge i_clk) begin
    if (hard || soft_req) begin
      o_crc_strobe <= 1'b0;
      crc_pend_r <= 1'b0;
    end else begin
      o_crc_strobe <= crc_tick;
      crc_pend_r <= crc_tick;
    end
  end
  wire crc_err = crc_pend_r && i_crc_mismatch && cfg_d_r[`RAE_CFGD_CRC_EN];
  // Byte clock count
  // Low count bits that must be zero for 8, 4 or 2 clocks a byte
  reg [2:0] byte_mask;
  always @* begin
    byte_mask = 3'b111;
    case ({i_txn_mode[0], i_txn_ddr})
      2'b00: byte_mask = 3'b111;
      2'b01: byte_mask = 3'b011;
      2'b10: byte_mask = 3'b011;
      2'b11: byte_mask = 3'b001;
      default: byte_mask = 3'b111;
    endcase
  end
  // A leftover below one byte flags the transaction
  wire bitcnt_err = i_txn_end && ((i_txn_clocks[2:0] & byte_mask) != 3'b000);
  // Stream crosses into primary
  // Only a step down out of the secondary region in dual mode counts
  wire dual_err = i_stream_step && i_txn_mode[0] && (i_stream_prev > `RAE_PRIMARY_LAST)
                  && (i_stream_next <= `RAE_PRIMARY_LAST);
  // Reject bad-CRC transaction
  // The refusal follows the event by one cycle
  always @(posedge i_clk) begin
    if (hard) begin
      o_txn_reject <= 1'b0;
    end else begin
      o_txn_reject <= i_spi_crc_bad;
    end
  end
  // ---------------------------------------------------------------
  // Sticky flags
  // ---------------------------------------------------------------
  // Set vectors laid out as the register bits
  wire [7:0] stat_flags;
  wire [7:0] err_flags;
  wire [7:0] stat_set;
  wire [7:0] err_set;
  assign stat_set = {3'b000, bitcnt_err, i_spi_crc_bad, i_ro_write, i_partial, i_bad_addr};
  assign err_set = {1'b0, ref_done, 1'b0, crc_err, 2'b00, dual_err, init_done};
  rae_flags #(.N(8)) u_stat (
    .i_clk(i_clk),
    .i_rst(hard || soft_req),
    .i_set(stat_set),
    .i_clr_we(wr_ok && i_reg_addr == `RAE_ADDR_STAT_A),
    .i_clr(i_reg_wdata),
    .o_flags(stat_flags)
  );
  rae_flags #(.N(8)) u_err (
    .i_clk(i_clk),
    .i_rst(hard || soft_req),
    .i_set(err_set),
    .i_clr_we(wr_ok && i_reg_addr == `RAE_ADDR_ERR),
    .i_clr(i_reg_wdata),
    .o_flags(err_flags)
  );
  // ---------------------------------------------------------------
  // Alarm output
  // ---------------------------------------------------------------
  // Maskable sources in mask bit order
  wire [6:0] sources = {err_flags[`RAE_ERR_REF], stat_flags[`RAE_STAT_BITCNT],
                        err_flags[`RAE_ERR_MEMCRC], stat_flags[`RAE_STAT_SPICRC],
                        stat_flags[`RAE_STAT_RO], stat_flags[`RAE_STAT_PART],
                        stat_flags[`RAE_STAT_INVAL]};
  // Registered so decode glitches never reach the pin
  reg alarm_r;
  always @(posedge i_clk) begin
    if (hard) begin
      alarm_r <= 1'b1;
    end else begin
      alarm_r <= (|(sources & ~mask_r[6:0])) || err_flags[`RAE_ERR_RST] || in_init;
    end
  end
  // Open drain, low asserts
  // The pin is only ever pulled low, never driven high
  assign o_alarm_o = 1'b0;
  assign o_alarm_oe = alarm_r;
  // ---------------------------------------------------------------
  // Register readback
  // ---------------------------------------------------------------
  // Not-ready bit
  // Unimplemented addresses read back as zero
  always @(posedge i_clk) begin
    if (hard) begin
      o_reg_rdata <= 8'h00;
    end else begin
      case (i_reg_addr)
        `RAE_ADDR_CFG_A: o_reg_rdata <= cfg_a_r;
        `RAE_ADDR_STAT_A: o_reg_rdata <= {in_init, stat_flags[6:0]};
        `RAE_ADDR_CFG_D: o_reg_rdata <= cfg_d_r;
        `RAE_ADDR_MASK: o_reg_rdata <= mask_r;
        `RAE_ADDR_ERR: o_reg_rdata <= err_flags;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // rae_alarm

// ---- test/rae_alarm_sva.sv ----
// Checker for reset sequencing, alarm pin and register side effects
module rae_alarm_sva #(
  parameter INIT_CYC = 20,
  parameter REF_CYC = 10
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_reg_we,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  input wire i_spi_crc_bad,
  input wire o_core_reset,
  input wire o_outputs_zero,
  input wire o_spi_hiz,
  input wire o_crc_strobe,
  input wire o_txn_reject,
  input wire o_alarm_o,
  input wire o_alarm_oe,
  input wire o_alarm_pullup_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Init holds the cores for a bounded stretch
  sequence s_init_run;
    o_core_reset [*8] ##[1:30] !o_core_reset;
  endsequence
  sequence s_cfgd_write;
    i_reg_we && i_reg_addr == 8'h14 && !o_core_reset;
  endsequence
  a_pin_reset: assert property (
    !i_reset_n |-> o_spi_hiz && o_outputs_zero && o_core_reset) else $error("pin reset lost");
  a_init_bound: assert property ($fell(i_rst) |-> s_init_run) else $error("init length");
  a_alarm_init: assert property ($fell(o_core_reset) |-> ##2 o_alarm_oe)
    else $error("no alarm after init");
  a_pullup_bit: assert property (s_cfgd_write |=>
    {5'h00, o_alarm_pullup_en, 2'h0} == ($past(i_reg_wdata) & 8'h04)) else $error("pull-up");
  a_mask_top: assert property (i_reg_addr == 8'h16 |=> !o_reg_rdata[7])
    else $error("mask bit 7 set");
  a_crc_reject: assert property (##1 o_txn_reject == $past(i_spi_crc_bad))
    else $error("reject timing");
  // Check enable as last written by the host; the period only holds while it is on
  logic crc_on_r = 1'b0;
  always @(posedge i_clk) begin
    if (i_rst || o_core_reset) begin
      crc_on_r <= 1'b0;
    end else if (i_reg_we && i_reg_addr == 8'h14) begin
      crc_on_r <= i_reg_wdata[6];
    end
  end
  a_crc_period: assert property (@(posedge i_clk)
    disable iff (i_rst || o_core_reset || !crc_on_r)
    o_crc_strobe |=> !o_crc_strobe [*8] ##94 o_crc_strobe) else $error("crc period");
  a_open_drain: assert property (o_alarm_oe |-> o_alarm_o == 1'b0) else $error("pin high");
endmodule // rae_alarm_sva

bind rae_alarm rae_alarm_sva #(.INIT_CYC(INIT_CYC), .REF_CYC(REF_CYC)) i_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_reg_we(i_reg_we),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_spi_crc_bad(i_spi_crc_bad), .o_core_reset(o_core_reset), .o_outputs_zero(o_outputs_zero),
  .o_spi_hiz(o_spi_hiz), .o_crc_strobe(o_crc_strobe), .o_txn_reject(o_txn_reject),
  .o_alarm_o(o_alarm_o), .o_alarm_oe(o_alarm_oe), .o_alarm_pullup_en(o_alarm_pullup_en)
);

// ---- test/rae_host.sv ----
// Host model driving the single-byte register bus
module rae_host (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output logic o_we,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    o_we = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one-cycle write, clears flags by ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_we <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_we <= 1'b0;
    o_wdata <= ~d; // Stale data is not held
  endtask
  // Read data shows one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    repeat (2) @(posedge i_clk);
    #1 d = i_rdata;
  endtask
endmodule // rae_host

// ---- test/tb.sv ----
// Self-checking bench for the reset and alarm block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, i_reset_n = 1, i_por = 0, i_ref_low = 0, i_crc_mismatch = 0;
  logic i_txn_end = 0, i_txn_ddr = 0, i_stream_step = 0, e;
  logic [1:0] i_txn_mode = 2'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] i_txn_clocks = 8'h00, i_stream_prev = 8'h00, i_stream_next = 8'h00, m, b, c;
  logic [31:0] seed = 32'h0000_e857, r;
  wire we, pd, hz, zr, rs, rej, ao, oe, pu;
  wire [7:0] ad, wd, rdat;
  int bad_count = 0, compares = 0, n_cyc = 0;
  rae_alarm #(.INIT_CYC(20), .REF_CYC(10)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_reset_n(i_reset_n), .i_por(i_por), .i_reg_we(we), .i_reg_addr(ad), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .i_ref_low(i_ref_low), .i_crc_mismatch(i_crc_mismatch),
    .i_txn_end(i_txn_end), .i_txn_clocks(i_txn_clocks), .i_txn_mode(i_txn_mode),
    .i_txn_ddr(i_txn_ddr), .i_spi_crc_bad(ev[3]), .i_ro_write(ev[2]), .i_partial(ev[1]),
    .i_bad_addr(ev[0]), .i_stream_step(i_stream_step), .i_stream_prev(i_stream_prev),
    .i_stream_next(i_stream_next), .o_core_reset(rs), .o_outputs_zero(zr),
    .o_cores_powerdown(pd), .o_spi_hiz(hz), .o_crc_strobe(), .o_txn_reject(rej),
    .o_alarm_o(ao), .o_alarm_oe(oe), .o_alarm_pullup_en(pu));
  rae_host i_host (.i_clk(i_clk), .i_rdata(rdat), .o_we(we), .o_addr(ad), .o_wdata(wd));
  // Clock and hang guard
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected clock count error: a remainder below one byte
  function automatic logic exp_bitcnt(input logic [7:0] clocks, input logic [7:0] per_byte);
    return (clocks % per_byte) != 8'h00;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("register", d, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk) ev <= 4'h1 << k;
    @(posedge i_clk) ev <= 4'h0;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc(3);
    i_host.wr(8'h16, 8'h7f); // Ignored during init
    cyc(30);
    rdc(8'h00, 8'h10);
    rdc(8'h11, 8'h00);
    rdc(8'h14, 8'h04);
    rdc(8'h16, 8'h00);
    rdc(8'h17, 8'h01);
    chk("alarm", {7'h0, oe}, 8'h01);
    chk("powerdown", {6'h0, pd, zr}, 8'h03);
    i_host.wr(8'h17, 8'h00);
    rdc(8'h17, 8'h01);
    i_host.wr(8'h17, 8'h01);
    rdc(8'h17, 8'h00);
    chk("alarm", {7'h0, oe}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      r = xs();
      m = {1'b0, r[6:0]};
      i_host.wr(8'h16, m);
      pulse(k);
      #1 chk("reject", {7'h0, rej}, {7'h0, k == 3});
      cyc(2);
      chk("alarm", {7'h0, oe}, {7'h0, !m[k]});
      i_host.wr(8'h11, 8'h00);
      rdc(8'h11, 8'h01 << k);
      i_host.wr(8'h11, 8'h01 << k);
      rdc(8'h11, 8'h00);
      chk("alarm", {7'h0, oe}, 8'h00);
    end
    fork
      i_host.wr(8'h11, 8'h04);
      pulse(2);
    join
    rdc(8'h11, 8'h04);
    i_host.wr(8'h11, 8'h04);
    for (int j = 0; j < 8; j++) begin
      r = xs();
      b = 8'h08 >> j[1] >> j[2];
      c = j[0] ? r[7:0] : b * 8'h03;
      e = exp_bitcnt(c, b);
      @(posedge i_clk);
      {i_txn_end, i_txn_clocks, i_txn_mode, i_txn_ddr} <= {1'b1, c, 1'b0, j[1], j[2]};
      @(posedge i_clk) i_txn_end <= 1'b0;
      rdc(8'h11, {3'h0, e, 4'h0});
      i_host.wr(8'h11, 8'h10);
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk) {i_txn_mode, i_stream_step, i_stream_prev, i_stream_next} <=
        {1'b0, j[0], 1'b1, 8'h28, 8'h1e};
      @(posedge i_clk) i_stream_step <= 1'b0;
      rdc(8'h17, {6'h0, j[0], 1'b0});
      i_host.wr(8'h17, 8'h02);
    end
    i_host.wr(8'h16, 8'h00);
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk) i_ref_low <= 1'b1;
      cyc(j ? 15 : 5);
      @(posedge i_clk) i_ref_low <= 1'b0;
      rdc(8'h17, j ? 8'h40 : 8'h00);
      chk("alarm", {7'h0, oe}, j ? 8'h01 : 8'h00);
      i_host.wr(8'h17, 8'h40);
    end
    @(posedge i_clk) i_crc_mismatch <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      i_host.wr(8'h14, j ? 8'h44 : 8'h04);
      cyc(110);
      rdc(8'h17, j ? 8'h10 : 8'h00);
    end
    @(posedge i_clk) i_crc_mismatch <= 1'b0;
    i_host.wr(8'h14, 8'h40);
    cyc(1);
    chk("pullup", {7'h0, pu}, 8'h00);
    i_host.wr(8'h00, 8'h91);
    cyc(2);
    chk("core reset", {7'h0, rs}, 8'h01);
    rdc(8'h11, 8'h80);
    cyc(30);
    rdc(8'h00, 8'h10);
    rdc(8'h14, 8'h04);
    rdc(8'h17, 8'h01);
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk) {i_reset_n, i_por} <= j ? 2'b11 : 2'b00;
      cyc(3);
      chk("hiz", {6'h0, hz, zr}, 8'h03);
      @(posedge i_clk) {i_reset_n, i_por} <= 2'b10;
      cyc(30);
      rdc(8'h17, 8'h01);
    end
    end_of_test();
  end
endmodule // tb
